// ===== logic/configurable_unified_cache.sv
`timescale 1ns/100ps
`default_nettype none
`include "cache_params.svh"
module configurable_unified_cache
  import cache_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        cfgWrite,
  input  wire logic        cfgSuper,
  input  wire logic [1:0]  cfgWdata,
  output logic      [1:0]  cfgMode,
  output logic             cfgDenied,
  input  wire logic        cpuReq,
  input  wire logic        cpuFetch,
  input  wire logic        cpuWrite,
  input  wire logic [31:0] cpuAddr,
  input  wire logic [31:0] cpuWdata,
  output logic             cpuBusy,
  output logic             cpuDone,
  output logic      [31:0] cpuRdata,
  output logic             extReq,
  output logic             extBurst,
  output logic             extWrite,
  output logic      [31:0] extAddr,
  output logic      [31:0] extWdata,
  input  wire logic        extAck,
  input  wire logic [31:0] extRdata
);
  // ----------------------------------------------------------------
  // Storage and helpers
  // ----------------------------------------------------------------
  logic [`TAG_W-1:0]       tagArr [`CACHE_LINES];
  logic [`CACHE_LINES-1:0] validReg;
  logic [31:0]             dataArr [`CACHE_WORDS];
  logic [31:0]             lineBuf [`LINE_WORDS];
  state_type               state_reg;
  mode_type                modeReg;
  logic [1:0]              cnt_reg;
  logic [`IDX_W-1:0]       idx_reg;
  logic [31:0]             addr_reg;

  function automatic logic [`IDX_W-1:0] lineIndex(input logic [31:0] a, input logic f,
                                                  input mode_type m);
    if (m == `MODE_SPLIT)
      lineIndex = {~f, a[`HALF_IDX_MSB:`OFS_LSB]};
    else
      lineIndex = a[`TAG_LSB:`OFS_LSB];
  endfunction : lineIndex

  function automatic logic cacheable(input logic f, input mode_type m);
    if (m == `MODE_SPLIT)
      cacheable = 1'b1;
    else if (m == `MODE_DATA)
      cacheable = ~f;
    else
      cacheable = f;
  endfunction : cacheable

  logic [`IDX_W-1:0]  reqIdx;
  logic [`WIDX_W-1:0] reqWord;
  logic               reqCache;
  logic               reqHit;
  logic               take;
  logic               fillLast;
  assign reqIdx   = lineIndex(cpuAddr, cpuFetch, modeReg);
  assign reqWord  = {reqIdx, cpuAddr[`OFS_LSB-1:`WORD_LSB]};
  assign reqCache = cacheable(cpuFetch, modeReg);
  assign reqHit   = reqCache && validReg[reqIdx] &&
                    (tagArr[reqIdx] == cpuAddr[31:`TAG_LSB]);
  assign take     = cpuReq && (state_reg == ST_IDLE);
  assign fillLast = (state_reg == ST_FILL) && extAck && (cnt_reg == `CNT_LAST);

  // ----------------------------------------------------------------
  // Setup register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      modeReg   <= `MODE_RESET;
      cfgMode   <= `MODE_RESET;
      cfgDenied <= 1'b0;
    end
    else
    begin
      cfgDenied <= cfgWrite && !cfgSuper;
      if (cfgWrite && cfgSuper)
      begin
        modeReg <= cfgWdata;
        cfgMode <= cfgWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 2'h0;
      idx_reg   <= '0;
      addr_reg  <= '0;
      cpuBusy   <= 1'b0;
      cpuDone   <= 1'b0;
      cpuRdata  <= '0;
      extReq    <= 1'b0;
      extBurst  <= 1'b0;
      extWrite  <= 1'b0;
      extAddr   <= '0;
      extWdata  <= '0;
    end
    else
    begin
      cpuDone <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (take)
          begin
            idx_reg  <= reqIdx;
            addr_reg <= cpuAddr;
            cnt_reg  <= 2'h0;
            if (cpuWrite)
            begin
              state_reg <= ST_WRITE;
              cpuBusy   <= 1'b1;
              extReq    <= 1'b1;
              extWrite  <= 1'b1;
              extAddr   <= cpuAddr;
              extWdata  <= cpuWdata;
            end
            else if (reqHit)
            begin
              cpuDone  <= 1'b1;
              cpuRdata <= dataArr[reqWord];
            end
            else if (reqCache)
            begin
              state_reg <= ST_FILL;
              cpuBusy   <= 1'b1;
              extReq    <= 1'b1;
              extBurst  <= 1'b1;
              extAddr   <= {cpuAddr[31:`OFS_LSB], 4'h0};
            end
            else
            begin
              state_reg <= ST_SINGLE;
              cpuBusy   <= 1'b1;
              extReq    <= 1'b1;
              extAddr   <= cpuAddr;
            end
          end
        end
        ST_FILL:
        begin
          if (extAck)
          begin
            cnt_reg <= cnt_reg + 2'h1;
            if (cnt_reg == addr_reg[`OFS_LSB-1:`WORD_LSB])
              cpuRdata <= extRdata;
            if (cnt_reg == `CNT_LAST)
            begin
              state_reg <= ST_IDLE;
              cpuBusy   <= 1'b0;
              cpuDone   <= 1'b1;
              extReq    <= 1'b0;
              extBurst  <= 1'b0;
            end
          end
        end
        ST_SINGLE, ST_WRITE:
        begin
          if (extAck)
          begin
            state_reg <= ST_IDLE;
            cpuBusy   <= 1'b0;
            cpuDone   <= 1'b1;
            extReq    <= 1'b0;
            extWrite  <= 1'b0;
            if (state_reg == ST_SINGLE)
              cpuRdata <= extRdata;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fill buffer and arrays
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if ((state_reg == ST_FILL) && extAck)
      lineBuf[cnt_reg] <= extRdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (fillLast)
    begin
      for (int i = 0; i < `LINE_WORDS - 1; i++)
        dataArr[{idx_reg, i[1:0]}] <= lineBuf[i];
      dataArr[{idx_reg, `CNT_LAST}] <= extRdata;
      tagArr[idx_reg] <= addr_reg[31:`TAG_LSB];
    end
    else if (take && cpuWrite && reqHit)
      dataArr[reqWord] <= cpuWdata;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      validReg <= '0;
    else
    begin
      // Invalidate on setup change; a fill ending in the same cycle still lands
      if (cfgWrite && cfgSuper)
        validReg <= '0;
      if (fillLast)
        validReg[idx_reg] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence seqMissTaken;
    take && !cpuWrite && reqCache && !reqHit && !(cfgWrite && cfgSuper);
  endsequence
  sequence seqFillEnd;
    fillLast;
  endsequence

  AST_CFG_SUPER: assert property (cfgWrite && !cfgSuper |=> $stable(cfgMode) && cfgDenied)
    else $error("user write changed setup");
  AST_HIT_ONE: assert property (take && !cpuWrite && reqHit |=> cpuDone && !cpuBusy)
    else $error("hit not done in one cycle");
  AST_HIT_DATA: assert property (take && !cpuWrite && reqHit
    |=> cpuRdata == $past(dataArr[reqWord]))
    else $error("hit data wrong");
  AST_MISS_FILL: assert property (seqMissTaken |=> extReq && extBurst && !extWrite
    && extAddr[3:0] == 4'h0)
    else $error("miss did not start line fetch");
  AST_FILL_VALID: assert property (seqFillEnd ##1 1'b1 |-> validReg[$past(idx_reg)] && cpuDone)
    else $error("fill did not validate line");
  AST_BUF: assert property ((state_reg == ST_FILL) && extAck && !fillLast
    |=> lineBuf[$past(cnt_reg)] == $past(extRdata))
    else $error("fill buffer missed word");
  AST_WT: assert property (take && cpuWrite |=> extReq && extWrite
    && extWdata == $past(cpuWdata))
    else $error("write not sent out");
  AST_WHIT: assert property (take && cpuWrite && reqHit
    |=> dataArr[$past(reqWord)] == $past(cpuWdata))
    else $error("write hit not stored");
  AST_SPLIT: assert property (modeReg == `MODE_SPLIT |-> reqIdx[`IDX_W-1] == !cpuFetch)
    else $error("split index wrong half");
  AST_BYPASS: assert property (take && !cpuWrite && !reqCache |=> state_reg == ST_SINGLE)
    else $error("uncached access not bypassed");
endmodule : configurable_unified_cache
`default_nettype wire

// ===== shared/cache_params.svh
`ifndef CACHE_PARAMS_SVH
`define CACHE_PARAMS_SVH
`define CACHE_LINES      512
`define CACHE_WORDS      2048
`define LINE_WORDS       4
`define IDX_W            9
`define WIDX_W           11
`define TAG_W            20
`define TAG_LSB          12
`define OFS_LSB          4
`define WORD_LSB         2
`define HALF_IDX_MSB     11
`define MODE_INST        2'h0
`define MODE_DATA        2'h1
`define MODE_SPLIT       2'h2
`define MODE_RESET       2'h0
`define CNT_LAST         2'h3
`endif

// ===== shared/cache_pkg.sv
package cache_pkg;
  typedef logic [1:0] mode_type;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_FILL   = 4'h2,
    ST_SINGLE = 4'h4,
    ST_WRITE  = 4'h8
  } state_type;
endpackage : cache_pkg

// ===== sim/ext_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ext_mem_model
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  waitSet,
  input  wire logic        extReq,
  input  wire logic        extBurst,
  input  wire logic        extWrite,
  input  wire logic [31:0] extAddr,
  input  wire logic [31:0] extWdata,
  output logic             extAck,
  output logic      [31:0] extRdata
);
  // ----------
  // Memory side
  // ----------
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  beat;
  logic [3:0]  waitCnt;
  logic [31:0] a;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extAck <= 1'b0;
      beat <= 2'h0;
      waitCnt <= 4'h0;
      extRdata <= 32'h5A5A_0F0F;
    end
    else
    begin
      extAck <= 1'b0;
      extRdata <= ~extRdata;
      a = extBurst ? {extAddr[31:4], beat, 2'h0} : extAddr;
      if (extReq && !extAck && waitCnt != waitSet)
        waitCnt <= waitCnt + 4'h1;
      else if (extReq && !extAck)
      begin
        waitCnt <= 4'h0;
        extAck <= 1'b1;
        beat <= extBurst ? beat + 2'h1 : 2'h0;
        if (extWrite)
          mem[a] = extWdata;
        extRdata <= mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
      end
    end
  end
endmodule : ext_mem_model
`default_nettype wire

// ===== sim/test_configurable_unified_cache.sv
`timescale 1ns/100ps
`default_nettype none
`include "cache_params.svh"
module test_configurable_unified_cache
  import cache_pkg::*;
;
  logic        clk_sys, rst_n, cfgWrite, cfgSuper, cfgDenied;
  logic        cpuReq, cpuFetch, cpuWrite, cpuBusy, cpuDone;
  logic        extReq, extBurst, extWrite, extAck;
  mode_type    cfgWdata, cfgMode;
  logic [31:0] cpuAddr, cpuWdata, cpuRdata, extAddr, extWdata, extRdata;
  logic [31:0] rd, lastWr;
  logic [3:0]  waitSet;
  int          fails, checks, acks, n;
  configurable_unified_cache dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cfgWrite(cfgWrite), .cfgSuper(cfgSuper), .cfgWdata(cfgWdata),
    .cfgMode(cfgMode), .cfgDenied(cfgDenied), .cpuReq(cpuReq),
    .cpuFetch(cpuFetch), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
    .cpuWdata(cpuWdata), .cpuBusy(cpuBusy), .cpuDone(cpuDone),
    .cpuRdata(cpuRdata), .extReq(extReq), .extBurst(extBurst),
    .extWrite(extWrite), .extAddr(extAddr), .extWdata(extWdata),
    .extAck(extAck), .extRdata(extRdata));
  ext_mem_model mem (.clk_sys(clk_sys), .rst_n(rst_n), .waitSet(waitSet),
    .extReq(extReq), .extBurst(extBurst), .extWrite(extWrite),
    .extAddr(extAddr), .extWdata(extWdata), .extAck(extAck),
    .extRdata(extRdata));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (extReq && extAck)
    begin
      acks <= acks + 1;
      if (extWrite)
        lastWr <= extWdata;
    end
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] pat(input logic [31:0] x);
    return {x[15:0], ~x[15:0]};
  endfunction : pat
  task automatic close_out();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic f, input logic w, input logic [31:0] ad,
                     input logic [31:0] wd);
    acks = 0;
    cpuReq = 1'b1;
    cpuFetch = f;
    cpuWrite = w;
    cpuAddr = ad;
    cpuWdata = wd;
    @(posedge clk_sys);
    #1;
    cpuReq = 1'b0;
    n = 1;
    while (cpuDone !== 1'b1 && n < 100)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 100)
    begin
      fails++;
      $display("[ERR] %0t access timed out", $time);
      close_out();
    end
    else
      rd = cpuRdata;
  endtask : acc
  task automatic cfg(input logic s, input mode_type m);
    cfgWrite = 1'b1;
    cfgSuper = s;
    cfgWdata = m;
    @(posedge clk_sys);
    #1;
    cfgWrite = 1'b0;
  endtask : cfg
  // ----------
  // Scenarios
  // ----------
  task automatic t_inst();
    chk(cfgMode, `MODE_INST);
    acc(1'b1, 1'b0, 32'h0000_1238, 32'h0);
    chk(rd, pat(32'h0000_1238));
    chk(acks, 4);
    acc(1'b1, 1'b0, 32'h0000_1230, 32'h0);
    chk(n, 1);
    chk(rd, pat(32'h0000_1230));
    acc(1'b0, 1'b0, 32'h0000_2000, 32'h0);
    chk(acks, 1);
    chk(rd, pat(32'h0000_2000));
    cfg(1'b0, `MODE_DATA);
    chk(cfgDenied, 1'b1);
    chk(cfgMode, `MODE_INST);
    $display("inst mode test done");
  endtask : t_inst
  task automatic t_data();
    cfg(1'b1, `MODE_DATA);
    chk(cfgMode, `MODE_DATA);
    acc(1'b0, 1'b0, 32'h0000_3010, 32'h0);
    chk(acks, 4);
    acc(1'b0, 1'b1, 32'h0000_3014, 32'hCAFE_0001);
    chk(acks, 1);
    chk(lastWr, 32'hCAFE_0001);
    acc(1'b0, 1'b0, 32'h0000_3014, 32'h0);
    chk(n, 1);
    chk(rd, 32'hCAFE_0001);
    acc(1'b0, 1'b1, 32'h0000_5000, 32'hBEEF_0002);
    chk(acks, 1);
    chk(lastWr, 32'hBEEF_0002);
    acc(1'b0, 1'b0, 32'h0000_1FFC, 32'h0);
    acc(1'b0, 1'b0, 32'h0000_1FFC, 32'h0);
    chk(n, 1);
    $display("data mode test done");
  endtask : t_data
  task automatic t_split();
    waitSet = 4'h2;
    cfg(1'b1, `MODE_SPLIT);
    chk(cfgMode, `MODE_SPLIT);
    acc(1'b1, 1'b0, 32'h0000_1040, 32'h0);
    chk(acks, 4);
    acc(1'b0, 1'b0, 32'h0000_3040, 32'h0);
    chk(acks, 4);
    acc(1'b1, 1'b0, 32'h0000_1040, 32'h0);
    chk(n, 1);
    acc(1'b0, 1'b0, 32'h0000_3040, 32'h0);
    chk(n, 1);
    chk(rd, pat(32'h0000_3040));
    cfg(1'b1, 2'h3);
    chk(cfgMode, 32'h0000_0003);
    acc(1'b0, 1'b0, 32'h0000_2040, 32'h0);
    chk(acks, 1);
    $display("split mode test done");
  endtask : t_split
  initial
  begin
    {clk_sys, rst_n, cfgWrite, cfgSuper, cpuReq, cpuFetch, cpuWrite} = '0;
    {cfgWdata, cpuAddr, cpuWdata, waitSet, lastWr} = '0;
    {fails, checks, acks} = '0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    t_inst();
    t_data();
    t_split();
    close_out();
  end
endmodule : test_configurable_unified_cache
`default_nettype wire
